//--- inc/pcscfg_defs.svh
// pcscfg_defs.svh: offsets, field positions and reset values shared by
// both ends of the PCS configuration vector link.
// assumes nothing; included by its bare name, definitions only.
`ifndef PCSCFG_DEFS_SVH
`define PCSCFG_DEFS_SVH

// ****************************************************************
// device control register (register 0) field positions, and register 0 and register 4 reset values
// ****************************************************************
`define PCSCFG_R0_UNIDIR     5
`define PCSCFG_R0_RESTART    9
`define PCSCFG_R0_ISOLATE    10
`define PCSCFG_R0_PWRDN      11
`define PCSCFG_R0_AN_EN      12
`define PCSCFG_R0_LOOPBACK   14
`define PCSCFG_R0_RST_VAL    16'h1000
`define PCSCFG_R4_RST_VAL    16'h0020

// ****************************************************************
// device management write addresses and interrupt register fields
// ****************************************************************
`define PCSCFG_MA_CTRL       5'h00
`define PCSCFG_MA_ADV        5'h04
`define PCSCFG_MA_IRQ        5'h10
`define PCSCFG_IRQ_STAT_BIT  0
`define PCSCFG_IRQ_EN_BIT    1

// ****************************************************************
// fabric-side AXI4-Lite register map (byte addresses)
// ****************************************************************
`define PCSCFG_A_CTRL        8'h00
`define PCSCFG_A_ADV         8'h04
`define PCSCFG_A_CMD         8'h08
`define PCSCFG_A_STAT        8'h0C
`define PCSCFG_A_ISTAT       8'h10
`define PCSCFG_A_IMASK       8'h14
`define PCSCFG_CMD_CTRL      0
`define PCSCFG_CMD_ADV       1
`define PCSCFG_CMD_RESTART   2
`define PCSCFG_STAT_DONE     16
`define PCSCFG_STAT_BUSY     17
`define PCSCFG_RESP_OKAY     2'h0
`define PCSCFG_RESP_SLVERR   2'h2

`endif

//--- inc/pcscfg_pkg.sv
// pcscfg_pkg: types shared by the two ends of the configuration link.
// assumes pcscfg_defs.svh for all numeric constants.
package pcscfg_pkg;
  typedef logic [15:0] pcscfg_word_t;
  typedef logic [4:0]  pcscfg_ctrl_t;
  typedef logic [31:0] pcscfg_data_t;
  typedef enum logic [0:0] {
    PCSCFG_WR_IDLE = 1'b0,
    PCSCFG_WR_RESP = 1'b1
  } pcscfg_wr_state_t;
endpackage

//--- inc/pcscfg_if.sv
// pcscfg_if: configuration and status vectors between the fabric logic
// and the PCS. assumes both ends run on the one core clock.
`timescale 1ns/100ps
interface pcscfg_if;
  logic [15:0] status_word;
  logic [4:0]  control_setting;
  logic        control_load_strobe;
  logic [15:0] advertisement_setting_vector;
  logic        advertisement_load_strobe;
  logic        negotiation_restart_strobe;
  logic        negotiation_done_output;

  modport device (
    output status_word,
    input  control_setting,
    input  control_load_strobe,
    input  advertisement_setting_vector,
    input  advertisement_load_strobe,
    input  negotiation_restart_strobe,
    output negotiation_done_output
  );

  modport fabric (
    input  status_word,
    output control_setting,
    output control_load_strobe,
    output advertisement_setting_vector,
    output advertisement_load_strobe,
    output negotiation_restart_strobe,
    input  negotiation_done_output
  );
endinterface : pcscfg_if

//--- rtl/pcscfg_device.sv
// pcscfg_device: PCS end of the configuration vector link. holds the
// control and advertisement registers, their vector loads and the
// negotiation done indication.
// assumes the fabric drives the link from this same core clock and
// that a management engine writes through the mgmt_* port.
`timescale 1ns/100ps
`include "pcscfg_defs.svh"

module pcscfg_device #(
  parameter int MGMT_PRESENT    = 1,
  parameter int AUTONEG_PRESENT = 1
) (
  input  wire logic                 clk_i,
  input  wire logic                 reset_i,
  pcscfg_if.device                  link,
  input  wire logic                 mgmt_we_i,
  input  wire logic [4:0]           mgmt_addr_i,
  input  wire pcscfg_pkg::pcscfg_word_t mgmt_wdata_i,
  input  wire logic                 an_complete_i,
  input  wire pcscfg_pkg::pcscfg_word_t pcs_status_i,
  output pcscfg_pkg::pcscfg_word_t  ctrl_reg_o,
  output pcscfg_pkg::pcscfg_word_t  adv_reg_o,
  output logic [1:0]                irq_reg_o
);
  import pcscfg_pkg::*;

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (MGMT_PRESENT != 0 && MGMT_PRESENT != 1) begin : g_chk_mgmt
    $error("MGMT_PRESENT must be 0 or 1");
  end
  if (AUTONEG_PRESENT != 0 && AUTONEG_PRESENT != 1) begin : g_chk_an
    $error("AUTONEG_PRESENT must be 0 or 1");
  end

  // ****************************************************************
  // declarations
  // ****************************************************************
  pcscfg_word_t ctrl_reg;
  pcscfg_word_t ctrl_next;
  pcscfg_word_t adv_reg;
  pcscfg_word_t adv_next;
  pcscfg_word_t status_reg;
  logic         ctrl_strb_prev_reg;
  logic         adv_strb_prev_reg;
  logic         rst_strb_prev_reg;
  logic         an_prev_reg;
  logic         ctrl_edge;
  logic         adv_edge;
  logic         restart_edge;
  logic         an_rise;
  logic         irq_stat_reg;
  logic         irq_stat_next;
  logic         irq_en_reg;
  logic         irq_en_next;
  logic         hold_off_reg;
  logic         done_reg;
  logic         wr_ctrl;
  logic         wr_adv;
  logic         wr_irq;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // places the five vector bits into their register 0 fields and
  // leaves every other bit as it stands
  function automatic pcscfg_word_t apply_ctrl(input pcscfg_word_t cur,
                                              input pcscfg_ctrl_t vec);
    pcscfg_word_t r;
    r                       = cur;
    r[`PCSCFG_R0_UNIDIR]    = vec[0];
    r[`PCSCFG_R0_LOOPBACK]  = vec[1];
    r[`PCSCFG_R0_PWRDN]     = vec[2];
    r[`PCSCFG_R0_ISOLATE]   = vec[3];
    r[`PCSCFG_R0_AN_EN]     = vec[4];
    return r;
  endfunction

  // ****************************************************************
  // strobe edge detection
  // ****************************************************************
  // link inputs share this clock, so no synchroniser stands in front
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_strb_prev_reg <= 1'b0;
      adv_strb_prev_reg  <= 1'b0;
      rst_strb_prev_reg  <= 1'b0;
      an_prev_reg        <= 1'b0;
    end else begin
      ctrl_strb_prev_reg <= link.control_load_strobe;
      adv_strb_prev_reg  <= link.advertisement_load_strobe;
      rst_strb_prev_reg  <= link.negotiation_restart_strobe;
      an_prev_reg        <= an_complete_i;
    end
  end

  // a strobe held high loads once; the fabric must drop it to reload
  assign ctrl_edge    = link.control_load_strobe & ~ctrl_strb_prev_reg;
  assign adv_edge     = link.advertisement_load_strobe & ~adv_strb_prev_reg;
  assign restart_edge = link.negotiation_restart_strobe & ~rst_strb_prev_reg;
  assign an_rise      = an_complete_i & ~an_prev_reg;

  assign wr_ctrl = mgmt_we_i && (mgmt_addr_i == `PCSCFG_MA_CTRL);
  assign wr_adv  = mgmt_we_i && (mgmt_addr_i == `PCSCFG_MA_ADV);
  assign wr_irq  = mgmt_we_i && (mgmt_addr_i == `PCSCFG_MA_IRQ);

  // ****************************************************************
  // control register (register 0)
  // ****************************************************************
  always_comb begin
    ctrl_next = ctrl_reg;
    // restart is a self-clearing request bit
    ctrl_next[`PCSCFG_R0_RESTART] = 1'b0;
    if (MGMT_PRESENT == 0) begin
      // without management the vector drives the fields every cycle
      ctrl_next = apply_ctrl(ctrl_next, link.control_setting);
    end else begin
      if (wr_ctrl) begin
        ctrl_next = mgmt_wdata_i;
      end
      // a strobe edge wins over a management write in the same cycle for the five vector fields; other bits take the write
      if (ctrl_edge) begin
        ctrl_next = apply_ctrl(ctrl_next, link.control_setting);
      end
    end
    if (AUTONEG_PRESENT != 0 && restart_edge) begin
      ctrl_next[`PCSCFG_R0_RESTART] = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_reg <= `PCSCFG_R0_RST_VAL;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ****************************************************************
  // advertisement register (register 4)
  // ****************************************************************
  always_comb begin
    adv_next = adv_reg;
    if (MGMT_PRESENT == 0) begin
      adv_next = link.advertisement_setting_vector;
    end else begin
      if (wr_adv) begin
        adv_next = mgmt_wdata_i;
      end
      if (adv_edge) begin
        adv_next = link.advertisement_setting_vector;
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      adv_reg <= `PCSCFG_R4_RST_VAL;
    end else begin
      adv_reg <= adv_next;
    end
  end

  // ****************************************************************
  // negotiation done interrupt (management present)
  // ****************************************************************
  // completion setting the sticky bit wins over a clearing write
  always_comb begin
    irq_en_next   = irq_en_reg;
    irq_stat_next = irq_stat_reg;
    if (wr_irq) begin
      irq_en_next = mgmt_wdata_i[`PCSCFG_IRQ_EN_BIT];
      if (mgmt_wdata_i[`PCSCFG_IRQ_STAT_BIT]) begin
        irq_stat_next = 1'b0;
      end
    end
    if (an_rise) begin
      irq_stat_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_en_reg   <= 1'b0;
      irq_stat_reg <= 1'b0;
    end else begin
      irq_en_reg   <= irq_en_next;
      irq_stat_reg <= irq_stat_next;
    end
  end

  // ****************************************************************
  // restart hold-off (management absent)
  // ****************************************************************
  // after a restart the done level stays low until the engine has
  // dropped its completion, so a stale completion never shows
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      hold_off_reg <= 1'b0;
    end else if (restart_edge) begin
      hold_off_reg <= 1'b1;
    end else if (!an_complete_i) begin
      hold_off_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      done_reg <= 1'b0;
    end else if (AUTONEG_PRESENT == 0) begin
      done_reg <= 1'b0;
    end else if (MGMT_PRESENT != 0) begin
      done_reg <= irq_stat_next & irq_en_next;
    end else begin
      done_reg <= an_complete_i & ~hold_off_reg & ~restart_edge;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      status_reg <= '0;
    end else begin
      status_reg <= pcs_status_i;
    end
  end

  assign link.status_word             = status_reg;
  assign link.negotiation_done_output = done_reg;
  assign ctrl_reg_o                   = ctrl_reg;
  assign adv_reg_o                    = adv_reg;
  assign irq_reg_o                    = {irq_en_reg, irq_stat_reg};

endmodule // pcscfg_device

//--- rtl/pcscfg_fabric.sv
// pcscfg_fabric: user-logic end of the configuration vector link,
// commanded over AXI4-Lite. drives vectors and load strobes, reports
// status and raises irq_o on a rise of negotiation_done_output, when unmasked.
// assumes the device runs on this same clock.
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "pcscfg_defs.svh"

module pcscfg_fabric (
  input  wire logic                     clk_i,
  input  wire logic                     reset_n_i,
  pcscfg_if.fabric                      link,
  input  wire logic [7:0]               s_axi_awaddr_i,
  input  wire logic                     s_axi_awvalid_i,
  output logic                          s_axi_awready_o,
  input  wire pcscfg_pkg::pcscfg_data_t s_axi_wdata_i,
  input  wire logic [3:0]               s_axi_wstrb_i,
  input  wire logic                     s_axi_wvalid_i,
  output logic                          s_axi_wready_o,
  output logic [1:0]                    s_axi_bresp_o,
  output logic                          s_axi_bvalid_o,
  input  wire logic                     s_axi_bready_i,
  input  wire logic [7:0]               s_axi_araddr_i,
  input  wire logic                     s_axi_arvalid_i,
  output logic                          s_axi_arready_o,
  output pcscfg_pkg::pcscfg_data_t      s_axi_rdata_o,
  output logic [1:0]                    s_axi_rresp_o,
  output logic                          s_axi_rvalid_o,
  input  wire logic                     s_axi_rready_i,
  output logic                          irq_o
);
  import pcscfg_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  pcscfg_wr_state_t wr_state_reg;
  logic             aw_got_reg;
  logic             w_got_reg;
  logic [7:0]       waddr_reg;
  pcscfg_data_t     wdata_reg;
  logic [3:0]       wstrb_reg;
  pcscfg_data_t     wmask;
  logic             do_write;
  logic [4:0]       ctrl_reg;
  pcscfg_word_t     adv_reg;
  logic [2:0]       pend_reg;
  logic [2:0]       strb_reg;
  logic             done_prev_reg;
  logic             istat_reg;
  logic             imask_reg;
  logic             irq_reg;
  logic             awready_reg;
  logic             wready_reg;
  logic             bvalid_reg;
  logic [1:0]       bresp_reg;
  logic             arready_reg;
  logic             rvalid_reg;
  pcscfg_data_t     rdata_reg;
  logic [1:0]       rresp_reg;

  // ****************************************************************
  // write channel: address and data taken in either order
  // ****************************************************************
  assign do_write = (wr_state_reg == PCSCFG_WR_IDLE) && aw_got_reg && w_got_reg;
  assign wmask    = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                     {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wr_state_reg <= PCSCFG_WR_IDLE;
      aw_got_reg   <= 1'b0;
      w_got_reg    <= 1'b0;
      awready_reg  <= 1'b1;
      wready_reg   <= 1'b1;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= `PCSCFG_RESP_OKAY;
      waddr_reg    <= '0;
      wdata_reg    <= '0;
      wstrb_reg    <= '0;
    end else begin
      if (s_axi_awvalid_i && awready_reg) begin
        aw_got_reg  <= 1'b1;
        awready_reg <= 1'b0;
        waddr_reg   <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && wready_reg) begin
        w_got_reg  <= 1'b1;
        wready_reg <= 1'b0;
        wdata_reg  <= s_axi_wdata_i;
        wstrb_reg  <= s_axi_wstrb_i;
      end
      case (wr_state_reg)
        PCSCFG_WR_IDLE: begin
          if (do_write) begin
            aw_got_reg   <= 1'b0;
            w_got_reg    <= 1'b0;
            bvalid_reg   <= 1'b1;
            bresp_reg    <= (waddr_reg > `PCSCFG_A_IMASK || waddr_reg[1:0] != 2'h0) ?
                            `PCSCFG_RESP_SLVERR : `PCSCFG_RESP_OKAY;
            wr_state_reg <= PCSCFG_WR_RESP;
          end
        end
        PCSCFG_WR_RESP: begin
          if (s_axi_bready_i) begin
            bvalid_reg   <= 1'b0;
            awready_reg  <= 1'b1;
            wready_reg   <= 1'b1;
            wr_state_reg <= PCSCFG_WR_IDLE;
          end
        end
        default: begin
          wr_state_reg <= PCSCFG_WR_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // vector registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ctrl_reg  <= '0;
      adv_reg   <= `PCSCFG_R4_RST_VAL;
      imask_reg <= 1'b0;
    end else if (do_write) begin
      if (waddr_reg == `PCSCFG_A_CTRL && wstrb_reg[0]) begin
        ctrl_reg <= wdata_reg[4:0];
      end
      if (waddr_reg == `PCSCFG_A_ADV) begin
        adv_reg <= (adv_reg & ~wmask[15:0]) | (wdata_reg[15:0] & wmask[15:0]);
      end
      if (waddr_reg == `PCSCFG_A_IMASK && wstrb_reg[0]) begin
        imask_reg <= wdata_reg[0];
      end
    end
  end

  // ****************************************************************
  // strobe sequencers
  // ****************************************************************
  // a command drops a high strobe for one cycle before raising it,
  // so every command makes a fresh rising edge at the device
  for (genvar i = 0; i < 3; i++) begin : g_strobe
    logic cmd_hit;
    assign cmd_hit = do_write && waddr_reg == `PCSCFG_A_CMD && wstrb_reg[0] && wdata_reg[i];
    always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
        pend_reg[i] <= 1'b0;
        strb_reg[i] <= 1'b0;
      end else if (cmd_hit) begin
        pend_reg[i] <= 1'b1;
        strb_reg[i] <= 1'b0;
      end else if (pend_reg[i]) begin
        pend_reg[i] <= 1'b0;
        strb_reg[i] <= 1'b1;
      end
    end
  end

  assign link.control_setting              = ctrl_reg;
  assign link.advertisement_setting_vector = adv_reg;
  assign link.control_load_strobe          = strb_reg[`PCSCFG_CMD_CTRL];
  assign link.advertisement_load_strobe    = strb_reg[`PCSCFG_CMD_ADV];
  assign link.negotiation_restart_strobe   = strb_reg[`PCSCFG_CMD_RESTART];

  // ****************************************************************
  // interrupt: done rise is sticky, write one clears, set wins
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      done_prev_reg <= 1'b0;
      istat_reg     <= 1'b0;
      irq_reg       <= 1'b0;
    end else begin
      done_prev_reg <= link.negotiation_done_output;
      if (link.negotiation_done_output && !done_prev_reg) begin
        istat_reg <= 1'b1;
      end else if (do_write && waddr_reg == `PCSCFG_A_ISTAT && wstrb_reg[0] && wdata_reg[0]) begin
        istat_reg <= 1'b0;
      end
      irq_reg <= istat_reg & imask_reg;
    end
  end

  // ****************************************************************
  // read channel
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= `PCSCFG_RESP_OKAY;
    end else if (s_axi_arvalid_i && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rresp_reg   <= `PCSCFG_RESP_OKAY;
      rdata_reg   <= '0;
      case (s_axi_araddr_i)
        `PCSCFG_A_CTRL:  rdata_reg[4:0]  <= ctrl_reg;
        `PCSCFG_A_ADV:   rdata_reg[15:0] <= adv_reg;
        `PCSCFG_A_CMD:   rdata_reg[2:0]  <= pend_reg;
        `PCSCFG_A_STAT: begin
          rdata_reg[15:0]              <= link.status_word;
          rdata_reg[`PCSCFG_STAT_DONE] <= link.negotiation_done_output;
          rdata_reg[`PCSCFG_STAT_BUSY] <= |pend_reg;
        end
        `PCSCFG_A_ISTAT: rdata_reg[0]    <= istat_reg;
        `PCSCFG_A_IMASK: rdata_reg[0]    <= imask_reg;
        default:         rresp_reg       <= `PCSCFG_RESP_SLVERR;
      endcase
    end else if (rvalid_reg && s_axi_rready_i) begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o  = wready_reg;
  assign s_axi_bvalid_o  = bvalid_reg;
  assign s_axi_bresp_o   = bresp_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rvalid_o  = rvalid_reg;
  assign s_axi_rdata_o   = rdata_reg;
  assign s_axi_rresp_o   = rresp_reg;
  assign irq_o           = irq_reg;

endmodule // pcscfg_fabric

//--- tb/pcscfg_monitor.sv
// pcscfg_monitor: timing checks on the configuration link.
// assumes one clock and one active-low reset for both ends.
`timescale 1ns/100ps
module pcscfg_monitor (
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic [15:0] status_word,
  input wire logic [4:0]  control_setting,
  input wire logic        control_load_strobe,
  input wire logic [15:0] advertisement_setting_vector,
  input wire logic        advertisement_load_strobe,
  input wire logic        negotiation_restart_strobe,
  input wire logic        negotiation_done_output,
  input wire logic        mgmt_we_i,
  input wire logic        an_complete_i,
  input wire logic [15:0] pcs_status_i,
  input wire logic [15:0] ctrl_reg_o,
  input wire logic [15:0] adv_reg_o,
  input wire logic [1:0]  irq_reg_o
);
  // ****************
  // link assertions
  // ****************
  wire [4:0] mapped = {ctrl_reg_o[14], ctrl_reg_o[12:10], ctrl_reg_o[5]};
  wire [4:0] wanted = {control_setting[1], control_setting[4], control_setting[2],
                       control_setting[3], control_setting[0]};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  a_status_copy: assert property ($past(reset_n_i)
    |-> status_word == $past(pcs_status_i)) else $error("status word stale");
  a_ctrl_load: assert property ($rose(control_load_strobe) |=> mapped == $past(wanted))
    else $error("control vector not loaded");
  a_held_once: assert property (control_load_strobe && $past(control_load_strobe)
    && !mgmt_we_i |=> $stable(mapped)) else $error("held strobe reloaded");
  a_adv_load: assert property ($rose(advertisement_load_strobe)
    |=> adv_reg_o == $past(advertisement_setting_vector)) else $error("adv not loaded");
  a_restart_pulse: assert property ($rose(negotiation_restart_strobe)
    |=> ctrl_reg_o[9] ##1 !ctrl_reg_o[9]) else $error("restart bit not one cycle");
  a_done_hold: assert property ($fell(negotiation_done_output) |-> $past(mgmt_we_i))
    else $error("done dropped without write");
  a_done_rise: assert property ($rose(an_complete_i) && irq_reg_o[1] && !mgmt_we_i
    |=> negotiation_done_output) else $error("done not raised");
  a_strobe_regap: assert property ($fell(control_load_strobe) |=> control_load_strobe)
    else $error("strobe low too long");
endmodule // pcscfg_monitor

//--- tb/pcs_config_status_vectors_tb.sv
// pcs_config_status_vectors_tb: both link ends, commanded over AXI4-Lite.
// assumes one 200 MHz clock; device reset is the inverse of reset_n_i.
`timescale 1ns/100ps
`include "pcscfg_defs.svh"
module pcs_config_status_vectors_tb;
  import pcscfg_pkg::*;
  logic         clk_i = 1'b0;
  logic         reset_n_i = 1'b0;
  logic [7:0]   awa = 8'h00;
  logic [7:0]   ara = 8'h00;
  pcscfg_data_t wd = 32'h0;
  logic         awv = 1'b0;
  logic         wv = 1'b0;
  logic         br = 1'b0;
  logic         arv = 1'b0;
  logic         rr = 1'b0;
  logic         awr, wr, bv, arr, rv, irq;
  logic [1:0]   bresp, rresp, irq_reg, r;
  pcscfg_data_t rd, d;
  logic         we = 1'b0;
  logic         an_done = 1'b0;
  logic [4:0]   ma = 5'h00;
  pcscfg_word_t mwd = 16'h0000;
  pcscfg_word_t pcs_status = 16'h0000;
  pcscfg_word_t ctrl_reg, adv_reg;
  int           error_cnt = 0;
  int           samples_checked = 0;

  pcscfg_if pcscfg_if_inst ();
  pcscfg_device pcscfg_device_inst (.clk_i(clk_i), .reset_i(!reset_n_i), .link(pcscfg_if_inst),
    .mgmt_we_i(we), .mgmt_addr_i(ma), .mgmt_wdata_i(mwd), .an_complete_i(an_done),
    .pcs_status_i(pcs_status), .ctrl_reg_o(ctrl_reg), .adv_reg_o(adv_reg), .irq_reg_o(irq_reg));
  pcscfg_fabric pcscfg_fabric_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .link(pcscfg_if_inst),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(br), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rr), .irq_o(irq));
  pcscfg_monitor pcscfg_monitor_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .status_word(pcscfg_if_inst.status_word), .control_setting(pcscfg_if_inst.control_setting),
    .control_load_strobe(pcscfg_if_inst.control_load_strobe),
    .advertisement_setting_vector(pcscfg_if_inst.advertisement_setting_vector),
    .advertisement_load_strobe(pcscfg_if_inst.advertisement_load_strobe),
    .negotiation_restart_strobe(pcscfg_if_inst.negotiation_restart_strobe),
    .negotiation_done_output(pcscfg_if_inst.negotiation_done_output), .mgmt_we_i(we),
    .an_complete_i(an_done), .pcs_status_i(pcs_status), .ctrl_reg_o(ctrl_reg),
    .adv_reg_o(adv_reg), .irq_reg_o(irq_reg));

  always #2.5 clk_i = ~clk_i;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic final_report;
    if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // pre-edge values are read at the falling edge, so no race with the design's flops
  task automatic axi_wr(input logic [7:0] a, input pcscfg_data_t v);
    logic aw_t, w_t, b_t;
    b_t = 1'b0;
    @(posedge clk_i);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    while (!b_t) begin
      @(negedge clk_i);
      aw_t = awv & awr;
      w_t = wv & wr;
      b_t = (bv === 1'b1);
      r = bresp;
      @(posedge clk_i);
      if (aw_t) awv <= 1'b0;
      if (w_t) wv <= 1'b0;
      if (b_t) br <= 1'b0;
    end
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic ar_t, r_t;
    r_t = 1'b0;
    @(posedge clk_i);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    while (!r_t) begin
      @(negedge clk_i);
      ar_t = arv & arr;
      r_t = (rv === 1'b1);
      r = rresp;
      d = rd;
      @(posedge clk_i);
      if (ar_t) arv <= 1'b0;
      if (r_t) rr <= 1'b0;
    end
  endtask
  task automatic mgmt_wr(input logic [4:0] a, input pcscfg_word_t v);
    @(posedge clk_i);
    we <= 1'b1;
    ma <= a;
    mwd <= v;
    @(posedge clk_i);
    we <= 1'b0;
  endtask
  task automatic s_ctrl_load;
    mgmt_wr(`PCSCFG_MA_CTRL, 16'h0000);
    axi_wr(`PCSCFG_A_CTRL, 32'h15);
    axi_wr(`PCSCFG_A_CMD, 32'h1);
    repeat (6) @(posedge clk_i);
    check({16'h0, ctrl_reg}, 32'h1820, "control load");
    axi_wr(`PCSCFG_A_CTRL, 32'h0A);
    repeat (6) @(posedge clk_i);
    check({16'h0, ctrl_reg}, 32'h1820, "held strobe reload");
    mgmt_wr(`PCSCFG_MA_CTRL, 16'h0000);
    axi_wr(`PCSCFG_A_CMD, 32'h1);
    repeat (6) @(posedge clk_i);
    check({16'h0, ctrl_reg}, 32'h4400, "control reload");
  endtask
  task automatic s_adv_load;
    axi_wr(`PCSCFG_A_ADV, 32'hA5C3);
    axi_wr(`PCSCFG_A_CMD, 32'h6);
    repeat (6) @(posedge clk_i);
    check({16'h0, adv_reg}, 32'hA5C3, "adv load");
    axi_wr(8'h30, 32'h1234);
    check({30'h0, r}, {30'h0, `PCSCFG_RESP_SLVERR}, "unmapped write");
    axi_rd(8'h30);
    check({30'h0, r}, {30'h0, `PCSCFG_RESP_SLVERR}, "unmapped read");
    check({16'h0, adv_reg}, 32'hA5C3, "adv after unmapped");
  endtask
  task automatic s_status;
    pcs_status <= 16'h5AA5;
    repeat (3) @(posedge clk_i);
    axi_rd(`PCSCFG_A_STAT);
    check({16'h0, d[15:0]}, 32'h5AA5, "status word");
  endtask
  task automatic s_irq;
    axi_wr(`PCSCFG_A_IMASK, 32'h1);
    mgmt_wr(`PCSCFG_MA_IRQ, 16'h0002);
    an_done <= 1'b1;
    repeat (4) @(posedge clk_i);
    an_done <= 1'b0;
    axi_rd(`PCSCFG_A_ISTAT);
    check(d, 32'h1, "istat set");
    check({31'h0, irq}, 32'h1, "irq raised");
    axi_wr(`PCSCFG_A_IMASK, 32'h0);
    repeat (3) @(posedge clk_i);
    check({31'h0, irq}, 32'h0, "irq masked");
    check({31'h0, pcscfg_if_inst.negotiation_done_output}, 32'h1, "done sticky");
    mgmt_wr(`PCSCFG_MA_IRQ, 16'h0003);
    axi_wr(`PCSCFG_A_ISTAT, 32'h1);
    axi_rd(`PCSCFG_A_ISTAT);
    check(d, 32'h0, "istat cleared");
    check({31'h0, pcscfg_if_inst.negotiation_done_output}, 32'h0, "done cleared");
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    s_ctrl_load();
    s_adv_load();
    s_status();
    s_irq();
    final_report();
  end
  // the tests need well under a thousand cycles; this bounds a hung handshake
  initial begin
    repeat (5000) @(posedge clk_i);
    error_cnt++;
    final_report();
  end
endmodule // pcs_config_status_vectors_tb
